// ===== pss_pkg.sv
package pss_pkg;
    // Clock and timing
    localparam longint unsigned CLK_HZ = 50_000_000;
    localparam int REPLY_DELAY_MS = 5;
    localparam longint unsigned REPLY_CYCLES = CLK_HZ / 1000 * REPLY_DELAY_MS;
    localparam int MINUTE_S = 60;
    localparam longint unsigned MINUTE_CYCLES = CLK_HZ * MINUTE_S;
    // Register byte offsets
    localparam logic [7:0] CONFIG_OFS = 8'h00;
    localparam logic [7:0] STATION_OFS = 8'h04;
    localparam logic [7:0] OPPORT_OFS = 8'h08;
    localparam logic [7:0] TIMEOUT_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] MASK_OFS = 8'h14;
    localparam logic [7:0] STATE_OFS = 8'h18;
    // Reset values and limits
    localparam logic [3:0] BAUD_9600 = 4'h3;
    localparam logic [6:0] STATION_RST = 7'h01;
    localparam logic [8:0] TIMEOUT_RST = 9'h001;
    localparam logic [8:0] TIMEOUT_MAX = 9'h1F4;
    localparam logic [1:0] OP_PARALLEL = 2'h0;
    localparam logic [1:0] OP_PRI = 2'h1;
    localparam logic [1:0] OP_SVC = 2'h2;
    // Status bit positions
    localparam int ST_TMO = 0;
    localparam int ST_REJ = 1;
    localparam int ST_BADID = 2;
    localparam int ST_W = 3;

    // Primary port line settings
    typedef struct packed {
        logic termEn;
        logic multiDrop;
        logic [1:0] parity;
        logic stop2;
        logic data8;
        logic [3:0] baud;
    } pss_cfg_type;

    localparam pss_cfg_type CFG_RST = '{termEn: 1'b0, multiDrop: 1'b0,
        parity: 2'h0, stop2: 1'b0, data8: 1'b1, baud: BAUD_9600};

    // Completed, checked frame from a port decoder
    typedef struct packed {
        logic valid;
        logic pumpOp;
        logic [6:0] addr;
    } pss_frame_type;

    // Timeout rewrite from the option-setting command
    typedef struct packed {
        logic valid;
        logic [8:0] minutes;
    } pss_tmo_wr_type;
endpackage

// ===== pss_supervisor.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module pss_supervisor
    import pss_pkg::*;
#(
    parameter logic [31:0] ReplyCycles = 32'(REPLY_CYCLES),
    parameter logic [31:0] MinuteCycles = 32'(MINUTE_CYCLES)
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pss_frame_type priFrame,
    input wire pss_frame_type svcFrame,
    input wire logic pumpRunning,
    input wire pss_tmo_wr_type optTmoWr,
    input wire logic replyDone,
    output pss_cfg_type cfg,
    output logic [6:0] stationId,
    output logic [1:0] opPort,
    output logic acceptPri,
    output logic acceptSvc,
    output logic replyGo,
    output logic pumpStop,
    output logic irq
);
    pss_cfg_type cfg_q;
    logic [6:0] stationId_q;
    logic [1:0] opPort_q;
    logic [8:0] timeout_q;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] status_d;
    logic [ST_W-1:0] mask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic acceptPri_q;
    logic acceptSvc_q;
    logic [31:0] replyCnt_q;
    logic replyWait_q;
    logic replyGo_q;
    logic [31:0] preCnt_q;
    logic [8:0] minutes_q;
    logic pumpStop_q;
    logic irq_q;

    // Bus decode
    wire setup = psel & ~penable & ~pready_q;
    wire wrEn = psel & penable & pwrite & pready_q;
    wire hitCfg = paddr == CONFIG_OFS;
    wire hitSta = paddr == STATION_OFS;
    wire hitOpp = paddr == OPPORT_OFS;
    wire hitTmo = paddr == TIMEOUT_OFS;
    wire hitStat = paddr == STATUS_OFS;
    wire hitMask = paddr == MASK_OFS;
    wire hitState = paddr == STATE_OFS;
    wire mapped = hitCfg | hitSta | hitOpp | hitTmo | hitStat | hitMask | hitState;
    wire [6:0] wrId = pwdata[6:0];
    wire idOk = wrId != 7'h00 && pwdata[31:7] == 25'h0;
    wire portOk = pwdata[1:0] != 2'h3;
    wire tmoOk = pwdata[31:9] == 23'h0 && pwdata[8:0] <= TIMEOUT_MAX;
    wire optOk = optTmoWr.valid && optTmoWr.minutes <= TIMEOUT_MAX;

    // Read mux
    wire [31:0] rdMux =
        hitCfg ? 32'(cfg_q) :
        hitSta ? 32'(stationId_q) :
        hitOpp ? 32'(opPort_q) :
        hitTmo ? 32'(timeout_q) :
        hitStat ? 32'(status_q) :
        hitMask ? 32'(mask_q) :
        hitState ? {21'h0, replyWait_q, pumpStop_q, minutes_q} : 32'h0;

    // Frame admission
    wire priAddrOk = ~cfg_q.multiDrop || priFrame.addr == stationId_q
        || priFrame.addr == 7'h00;
    wire priValid = priFrame.valid & priAddrOk;
    wire priGate = ~priFrame.pumpOp | (opPort_q == OP_PRI);
    wire svcGate = ~svcFrame.pumpOp | (opPort_q == OP_SVC);
    wire priTake = priValid & priGate;
    wire svcTake = svcFrame.valid & svcGate;
    wire rejPump = (priValid & ~priGate) | (svcFrame.valid & ~svcGate);
    wire selFrame = (opPort_q == OP_PRI && priValid)
        || (opPort_q == OP_SVC && svcFrame.valid);

    // Silence supervision
    wire tmoArmed = timeout_q != 9'h0 && opPort_q != OP_PARALLEL;
    wire minTick = preCnt_q == MinuteCycles - 32'h1;
    wire tmoHit = tmoArmed && pumpRunning && minutes_q >= timeout_q;
    wire replyEnd = replyWait_q && replyCnt_q == ReplyCycles - 32'h1;

    // Sticky events, set wins over the write-one clear
    wire [ST_W-1:0] evSet = {wrEn & hitSta & ~idOk, rejPump, tmoHit};
    wire [ST_W-1:0] evClr = (wrEn & hitStat) ? pwdata[ST_W-1:0] : '0;
    assign status_d = (status_q & ~evClr) | evSet;

    // Bus slave
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (ce) begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q <= setup ? rdMux : prdata_q;
        end
    end

    // Configuration registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= CFG_RST;
            stationId_q <= STATION_RST;
            opPort_q <= OP_PARALLEL;
            mask_q <= '0;
        end else if (ce && wrEn) begin
            if (hitCfg) begin
                cfg_q <= pwdata[$bits(pss_cfg_type)-1:0];
            end
            if (hitSta && idOk) begin
                stationId_q <= wrId;
            end
            if (hitOpp && portOk) begin
                opPort_q <= pwdata[1:0];
            end
            if (hitMask) begin
                mask_q <= pwdata[ST_W-1:0];
            end
        end
    end

    // Shared timeout, from bus or option command
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            timeout_q <= TIMEOUT_RST;
        end else if (ce) begin
            if (wrEn && hitTmo && tmoOk) begin
                timeout_q <= pwdata[8:0];
            end else if (optOk) begin
                timeout_q <= optTmoWr.minutes;
            end
        end
    end

    // Status, interrupt and accept strobes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= '0;
            irq_q <= 1'b0;
            acceptPri_q <= 1'b0;
            acceptSvc_q <= 1'b0;
        end else if (ce) begin
            status_q <= status_d;
            irq_q <= |(status_d & mask_q);
            acceptPri_q <= priTake;
            acceptSvc_q <= svcTake;
        end
    end

    // Reply turnaround delay on the primary port
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            replyWait_q <= 1'b0;
            replyGo_q <= 1'b0;
            replyCnt_q <= 32'h0;
        end else if (ce) begin
            if (priTake) begin
                replyWait_q <= 1'b1;
                replyGo_q <= 1'b0;
                replyCnt_q <= 32'h0;
            end else if (replyEnd) begin
                replyWait_q <= 1'b0;
                replyGo_q <= 1'b1;
            end else if (replyWait_q) begin
                replyCnt_q <= replyCnt_q + 32'h1;
            end else if (replyDone) begin
                replyGo_q <= 1'b0;
            end
        end
    end

    // Minute prescaler and silence counter
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            preCnt_q <= 32'h0;
            minutes_q <= 9'h0;
        end else if (ce) begin
            if (selFrame || !tmoArmed) begin
                preCnt_q <= 32'h0;
                minutes_q <= 9'h0;
            end else if (minTick) begin
                preCnt_q <= 32'h0;
                if (minutes_q != TIMEOUT_MAX) begin
                    minutes_q <= minutes_q + 9'h1;
                end
            end else begin
                preCnt_q <= preCnt_q + 32'h1;
            end
        end
    end

    // Pump stop holds until software clears the timeout event
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pumpStop_q <= 1'b0;
        end else if (ce) begin
            pumpStop_q <= status_d[ST_TMO];
        end
    end

    // Outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cfg = cfg_q;
    assign stationId = stationId_q;
    assign opPort = opPort_q;
    assign acceptPri = acceptPri_q;
    assign acceptSvc = acceptSvc_q;
    assign replyGo = replyGo_q;
    assign pumpStop = pumpStop_q;
    assign irq = irq_q;

    // Checks
    reply_delay_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        $rose(replyGo_q) |-> $past(replyCnt_q) == ReplyCycles - 32'h1)
        else $error("reply released before turnaround delay");

    station_range_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        stationId_q != 7'h00)
        else $error("station id left its range");

    port_legal_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        opPort_q != 2'h3)
        else $error("operating port holds an illegal code");

    pump_gate_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && priFrame.valid && priAddrOk && priFrame.pumpOp && opPort_q != OP_PRI
        |=> !acceptPri_q && status_q[ST_REJ])
        else $error("pump command taken from unselected port");

    other_cmd_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && svcFrame.valid && !svcFrame.pumpOp |=> acceptSvc_q)
        else $error("plain command refused on service port");

    stop_tmo_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && tmoHit |=> pumpStop_q && status_q[ST_TMO] ##1 irq_q || !mask_q[ST_TMO])
        else $error("timeout did not stop pump");

    tmo_off_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && timeout_q == 9'h0 |-> !tmoHit ##1 minutes_q == 9'h0)
        else $error("disabled timeout still counting");

    tmo_range_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        timeout_q <= TIMEOUT_MAX)
        else $error("timeout above its range");

    restart_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && selFrame |=> minutes_q == 9'h0 && preCnt_q == 32'h0)
        else $error("frame did not restart silence counter");

    cfg_write_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && wrEn && hitCfg |=> cfg_q == $past(pwdata[$bits(pss_cfg_type)-1:0]))
        else $error("line settings not taken from write");

    station_write_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && wrEn && hitSta && idOk |=> stationId_q == $past(wrId))
        else $error("legal station id not stored");

    bad_id_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && wrEn && hitSta && !idOk |=> $stable(stationId_q) && status_q[ST_BADID])
        else $error("illegal station id not refused");

    port_write_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && wrEn && hitOpp && !portOk |=> $stable(opPort_q))
        else $error("illegal port code was stored");

    svc_gate_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && svcFrame.valid && svcFrame.pumpOp && opPort_q != OP_SVC
        |=> !acceptSvc_q && status_q[ST_REJ])
        else $error("pump command taken from service port");

    pri_take_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && priFrame.valid && priAddrOk && !priFrame.pumpOp |=> acceptPri_q)
        else $error("plain command refused on primary port");

    opt_range_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && optTmoWr.valid && optTmoWr.minutes > TIMEOUT_MAX && !(wrEn && hitTmo)
        |=> $stable(timeout_q))
        else $error("option command stored timeout above range");

    opt_write_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        ce && optOk && !(wrEn && hitTmo && tmoOk) |=> timeout_q == $past(optTmoWr.minutes))
        else $error("option command timeout not stored");

    minutes_cap_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        minutes_q <= TIMEOUT_MAX)
        else $error("silence count passed its ceiling");

    stop_hold_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        pumpStop_q == status_q[ST_TMO])
        else $error("pump stop out of step with timeout event");

    reply_hold_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        replyWait_q |-> !replyGo_q)
        else $error("reply released during turnaround delay");

    reply_cov: cover property (@(posedge clock) disable iff (!arst_n) $rose(replyGo_q));
    stop_cov: cover property (@(posedge clock) disable iff (!arst_n) $rose(pumpStop_q));
    reject_cov: cover property (@(posedge clock) disable iff (!arst_n) rejPump && ce);
    irq_cov: cover property (@(posedge clock) disable iff (!arst_n) $rose(irq_q));
endmodule

// ===== pss_host_model.sv
`timescale 1ns/100ps
module pss_host_model
    import pss_pkg::*;
#(
    parameter int HoldCycles = 3
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic replyGo,
    output pss_frame_type priFrame,
    output pss_frame_type svcFrame,
    output logic replyDone
);
    logic [7:0] holdCnt_q;
    initial priFrame = '0;
    initial svcFrame = '0;
    // One checked frame on a port, valid for one clock cycle
    task automatic send_frame(input logic onSvc, input logic pump, input logic [6:0] addr);
        @(posedge clock);
        if (onSvc) begin
            svcFrame <= '{valid: 1'b1, pumpOp: pump, addr: addr};
        end else begin
            priFrame <= '{valid: 1'b1, pumpOp: pump, addr: addr};
        end
        @(posedge clock);
        priFrame <= '0;
        svcFrame <= '0;
        @(posedge clock);
    endtask
    // Listen for the reply, then release the line after a short hold
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            holdCnt_q <= 8'h00;
            replyDone <= 1'b0;
        end else begin
            replyDone <= replyGo && (holdCnt_q == 8'(HoldCycles));
            if (!replyGo) begin
                holdCnt_q <= 8'h00;
            end else if (holdCnt_q <= 8'(HoldCycles)) begin
                holdCnt_q <= holdCnt_q + 8'h01;
            end
        end
    end
endmodule

// ===== pss_supervisor_bench.sv
`timescale 1ns/100ps
module pump_serial_port_supervisor_bench import pss_pkg::*;;
    localparam int Rc = 20;
    localparam int Mc = 50;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, replyDone, acceptPri, acceptSvc, replyGo, pumpStop, irq;
    logic pumpRunning = 1'b0;
    pss_tmo_wr_type optTmoWr = '0;
    pss_frame_type priFrame, svcFrame;
    pss_cfg_type cfg;
    logic [6:0] stationId;
    logic [1:0] opPort;
    int fail_count = 0;
    int n_checks = 0;
    pss_supervisor #(.ReplyCycles(32'(Rc)), .MinuteCycles(32'(Mc))) dut (
        .clock(clock), .arst_n(arst_n), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .priFrame(priFrame), .svcFrame(svcFrame),
        .pumpRunning(pumpRunning), .optTmoWr(optTmoWr), .replyDone(replyDone), .cfg(cfg),
        .stationId(stationId), .opPort(opPort), .acceptPri(acceptPri),
        .acceptSvc(acceptSvc), .replyGo(replyGo), .pumpStop(pumpStop), .irq(irq));
    pss_host_model host (.clock(clock), .arst_n(arst_n), .replyGo(replyGo),
        .priFrame(priFrame), .svcFrame(svcFrame), .replyDone(replyDone));
    always #10 clock = ~clock;
    task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cb(input logic seen, input logic exp);
        ck({31'h0, seen}, {31'h0, exp});
    endtask
    // APB transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) fail_count++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        ck(rd, e);
    endtask
    task automatic fr(input logic s, input logic p, input logic [6:0] a);
        host.send_frame(s, p, a);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        rc(CONFIG_OFS, 32'h13);
        rc(STATION_OFS, 32'h1);
        rc(OPPORT_OFS, 32'h0);
        rc(TIMEOUT_OFS, 32'h1);
        rc(8'h1C, 32'h0);
        cb(err, 1'b1);
        wr(STATION_OFS, 32'h0);
        rc(STATUS_OFS, 32'h4);
        wr(STATUS_OFS, 32'h4);
        wr(STATION_OFS, 32'h80);
        rc(STATION_OFS, 32'h1);
        wr(STATION_OFS, 32'h7F);
        @(posedge clock);
        ck({25'h0, stationId}, 32'h7F);
        wr(OPPORT_OFS, 32'h3);
        rc(OPPORT_OFS, 32'h0);
        // Pump command refused on a port that is not selected
        fr(1'b1, 1'b1, 7'h00);
        cb(acceptSvc, 1'b0);
        fr(1'b0, 1'b1, 7'h00);
        cb(acceptPri, 1'b0);
        rc(STATUS_OFS, 32'h6);
        wr(STATUS_OFS, 32'h6);
        fr(1'b1, 1'b0, 7'h00);
        cb(acceptSvc, 1'b1);
        // Reply held back after a primary command
        fr(1'b0, 1'b0, 7'h00);
        cb(acceptPri, 1'b1);
        repeat (Rc - 2) @(posedge clock);
        cb(replyGo, 1'b0);
        @(posedge clock);
        cb(replyGo, 1'b0);
        @(posedge clock);
        cb(replyGo, 1'b1);
        repeat (4) @(posedge clock);
        cb(replyGo, 1'b1);
        @(posedge clock);
        cb(replyGo, 1'b0);
        wr(OPPORT_OFS, 32'h1);
        fr(1'b0, 1'b1, 7'h00);
        cb(acceptPri, 1'b1);
        ck({30'h0, opPort}, 32'h1);
        fr(1'b1, 1'b1, 7'h00);
        cb(acceptSvc, 1'b0);
        rc(STATUS_OFS, 32'h2);
        wr(STATUS_OFS, 32'h2);
        // Multi-drop addressing: foreign and own station address
        wr(CONFIG_OFS, 32'h113);
        @(posedge clock);
        ck({22'h0, cfg}, 32'h113);
        wr(STATION_OFS, 32'h5);
        fr(1'b0, 1'b0, 7'h06);
        cb(acceptPri, 1'b0);
        fr(1'b0, 1'b0, 7'h05);
        cb(acceptPri, 1'b1);
        // Timeout range and the option-command path
        @(posedge clock);
        optTmoWr <= '{valid: 1'b1, minutes: 9'h1F5};
        @(posedge clock);
        optTmoWr <= '{valid: 1'b1, minutes: 9'h007};
        @(posedge clock);
        optTmoWr <= '0;
        rc(TIMEOUT_OFS, 32'h7);
        wr(TIMEOUT_OFS, 32'h1F5);
        rc(TIMEOUT_OFS, 32'h7);
        wr(TIMEOUT_OFS, 32'h0);
        pumpRunning <= 1'b1;
        repeat (3 * Mc) @(posedge clock);
        cb(pumpStop, 1'b0);
        pumpRunning <= 1'b0;
        wr(TIMEOUT_OFS, 32'h2);
        wr(MASK_OFS, 32'h1);
        fr(1'b0, 1'b0, 7'h05);
        pumpRunning <= 1'b1;
        repeat (80) @(posedge clock);
        fr(1'b0, 1'b0, 7'h05);
        repeat (80) @(posedge clock);
        cb(pumpStop, 1'b0);
        repeat (40) @(posedge clock);
        cb(pumpStop, 1'b1);
        cb(irq, 1'b1);
        rc(STATUS_OFS, 32'h1);
        wr(MASK_OFS, 32'h0);
        repeat (3) @(posedge clock);
        cb(irq, 1'b0);
        pumpRunning <= 1'b0;
        fr(1'b0, 1'b0, 7'h05);
        wr(STATUS_OFS, 32'h1);
        repeat (3) @(posedge clock);
        cb(pumpStop, 1'b0);
        tally_and_finish();
    end
endmodule
